// [src/lsc_driver.v]
/*
 LCD segment/common driver top: mode select and key source data
 registers, slot timing, common and segment waveform generation,
 port 0E/0F select and key source multiplexing.
 Assumes CPU strobes are synchronous to clk; key returns are pins.
 Half-level common drive is shown as a separate mid enable.
*/
`include "lsc_consts.vh"
`default_nettype none
module lsc_driver (
    // Clock and reset
    input wire clk,
    input wire rst_b,
    // Segment memory port
    input wire mem_wr,
    input wire [3:0] mem_addr,
    input wire [3:0] mem_wdata,
    output wire [3:0] mem_rdata,
    // Register file / peripheral port
    input wire reg_wr,
    input wire [7:0] reg_addr,
    input wire [15:0] reg_wdata,
    output reg [15:0] reg_rdata_ff,
    // Commons: level and mid-bias select
    output reg common_line_a_ff,
    output reg common_line_b_ff,
    output reg common_a_mid_ff,
    output reg common_b_mid_ff,
    // Segment pins
    output reg [29:0] seg_out_ff,
    // Key return inputs
    input wire [3:0] key_return_port,
    output reg [3:0] key_return_ff,
    output reg key_slot_ff
);
    localparam [1:0] PH_0 = 2'd0;
    localparam [1:0] PH_1 = 2'd1;
    localparam [1:0] PH_2 = 2'd2;
    localparam [1:0] PH_3 = 2'd3;
    localparam [31:0] SLOT_LAST_W = `LSC_SLOT_CYC - 1;
    localparam [15:0] SLOT_LAST = SLOT_LAST_W[15:0];

    reg [3:0] mode_ff;
    reg [15:0] key_source_data_ff;
    reg [15:0] slot_cnt_ff;
    reg [1:0] phase_ff;
    reg key_mux_ff;
    reg [3:0] kr_meta_ff;
    wire [59:0] seg_bits;
    wire display_enable_flag = mode_ff[`LSC_BIT_DISP_EN];
    wire scan_source_enable_flag = mode_ff[`LSC_BIT_SCAN_EN];
    wire out_port_lo_group = mode_ff[`LSC_BIT_PORTE_EN];
    wire out_port_hi_group = mode_ff[`LSC_BIT_PORTF_EN];
    wire slot_end = (slot_cnt_ff == SLOT_LAST);

    lsc_seg_mem u_mem (
        .clk(clk),
        .rst_b(rst_b),
        .mem_wr(mem_wr),
        .mem_addr(mem_addr),
        .mem_wdata(mem_wdata),
        .mem_rdata_ff(mem_rdata),
        .seg_bits(seg_bits)
    );

    // Register writes
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_ff <= `LSC_MODE_RST;
            key_source_data_ff <= `LSC_KSRC_RST;
        end else begin
            if (reg_wr && reg_addr == `LSC_MODE_ADDR) begin
                mode_ff <= reg_wdata[3:0]; // R5
            end
            if (reg_wr && reg_addr == `LSC_KSRC_ADDR) begin
                key_source_data_ff <= reg_wdata; // R11
            end
        end
    end

    // Read mux; unknown addresses read as zero
    reg [15:0] nxt_rdata;
    always @* begin
        case (reg_addr)
            `LSC_MODE_ADDR: begin
                nxt_rdata = {12'h000, mode_ff};
            end
            `LSC_KSRC_ADDR: begin
                nxt_rdata = key_source_data_ff;
            end
            default: begin
                nxt_rdata = 16'h0000;
            end
        endcase
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata_ff <= 16'h0000;
        end else begin
            reg_rdata_ff <= nxt_rdata;
        end
    end

    // Slot timer: four 1 kHz slots per 250 Hz frame, 250 Hz display clock
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            slot_cnt_ff <= 16'h0000;
        end else if (slot_end) begin
            slot_cnt_ff <= 16'h0000;
        end else begin
            slot_cnt_ff <= slot_cnt_ff + 16'h0001;
        end
    end

    // Drive phase and key slot alternation
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            phase_ff <= PH_0;
            key_mux_ff <= 1'b0;
        end else if (slot_end) begin
            phase_ff <= phase_ff + 2'd1; // R17
            key_mux_ff <= ~key_mux_ff;
        end
    end

    // Key return pins: first sync stage
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            kr_meta_ff <= 4'h0;
        end else begin
            kr_meta_ff <= key_return_port;
        end
    end

    // Second stage, gated by scan enable
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            key_return_ff <= 4'h0;
        end else begin
            key_return_ff <= scan_source_enable_flag ? kr_meta_ff : 4'h0; // R12
        end
    end

    // Common decode: A high in 0, low in 2, mid in 1/3; B lags by 1/4
    reg nxt_ca;
    reg nxt_cb;
    reg nxt_am;
    reg nxt_bm;
    always @* begin
        nxt_ca = 1'b0;
        nxt_cb = 1'b0;
        nxt_am = 1'b0;
        nxt_bm = 1'b0;
        if (display_enable_flag) begin // R18
            case (phase_ff) // R3
                PH_0: begin
                    nxt_ca = 1'b1;
                    nxt_cb = 1'b0;
                    nxt_am = 1'b0;
                    nxt_bm = 1'b1;
                end
                PH_1: begin
                    nxt_ca = 1'b0;
                    nxt_cb = 1'b1;
                    nxt_am = 1'b1;
                    nxt_bm = 1'b0;
                end
                PH_2: begin
                    nxt_ca = 1'b0;
                    nxt_cb = 1'b0;
                    nxt_am = 1'b0;
                    nxt_bm = 1'b1;
                end
                PH_3: begin
                    nxt_ca = 1'b0;
                    nxt_cb = 1'b0;
                    nxt_am = 1'b1;
                    nxt_bm = 1'b0;
                end
                default: begin
                    nxt_ca = 1'b0;
                    nxt_cb = 1'b0;
                    nxt_am = 1'b0;
                    nxt_bm = 1'b0;
                end
            endcase
        end
    end

    // Segment level: opposite the selected common lights the dot
    wire [29:0] disp_seg;
    genvar g;
    generate
        for (g = 0; g < 30; g = g + 1) begin : seg_lvl
            wire dot_a = seg_bits[g*2]; // R14
            wire dot_b = seg_bits[g*2+1]; // R2
            assign disp_seg[g] = phase_ff[0] ? (dot_b ^ nxt_cb) : (dot_a ^ nxt_ca); // R1 R15
        end
    endgenerate

    // Port groups take raw register bits in place of segment levels
    reg [29:0] port_seg;
    always @* begin
        port_seg = display_enable_flag ? disp_seg : 30'h0; // R18
        if (out_port_lo_group) begin // R6 R7
            port_seg[22] = seg_bits[44]; // R16
            port_seg[23] = seg_bits[45];
            port_seg[24] = seg_bits[46];
            port_seg[25] = seg_bits[47];
        end
        if (out_port_hi_group) begin // R6 R7
            port_seg[26] = seg_bits[52]; // R16
            port_seg[27] = seg_bits[53];
            port_seg[28] = seg_bits[54];
            port_seg[29] = seg_bits[55];
        end
    end

    // Key source overlay on the low sixteen pins, then blanking
    reg [29:0] nxt_seg;
    reg nxt_kslot;
    always @* begin
        nxt_kslot = scan_source_enable_flag && key_mux_ff;
        nxt_seg = port_seg;
        if (nxt_kslot) begin // R19
            nxt_seg[15:0] = key_source_data_ff; // R8 R9 R10
        end
        if (!display_enable_flag && !nxt_kslot) begin
            nxt_seg[21:0] = 22'h0; // R4
        end
    end

    // Common outputs
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            common_line_a_ff <= 1'b0;
            common_line_b_ff <= 1'b0;
            common_a_mid_ff <= 1'b0;
            common_b_mid_ff <= 1'b0;
        end else begin
            common_line_a_ff <= nxt_ca;
            common_line_b_ff <= nxt_cb;
            common_a_mid_ff <= nxt_am;
            common_b_mid_ff <= nxt_bm;
        end
    end

    // Segment outputs
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            seg_out_ff <= 30'h0;
        end else begin
            seg_out_ff <= nxt_seg;
        end
    end

    // Key slot marker
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            key_slot_ff <= 1'b0;
        end else begin
            key_slot_ff <= nxt_kslot;
        end
    end
endmodule
`default_nettype wire

// [src/lsc_consts.vh]
/*
 Constants for the LCD segment/common driver: register offsets,
 field positions, reset values and timing counts.
 Assumes a 40 MHz system clock.
*/
// Overview of operation
// R1 - Drive up to 60 dots, two commons
// R2 - Each segment line controls two dots
// R3 - Half duty, half bias, full supply swing
// R4 - Display off holds commons and segments low
// R5 - Mode select register at address 10H
// R6 - Top eight segments as two port groups
// R7 - Per group select: segment or port
// R8 - Lowest sixteen segments double as key sources
// R9 - Key source and segment share time slots
// R10 - Mode register enables key source output
// R11 - Key source data register at 42H
// R12 - Four key return inputs when scanning
// R13 - Segment registers live in data memory
// R14 - One nibble holds four dots
// R15 - Bit one lights dot, zero darkens
// R16 - Port pins driven from segment register bits
// R17 - 125 Hz frame from 250 Hz clock; code gives a 250 Hz frame of four 1 kHz slots
// R18 - Commons and segments only when display enabled
// R19 - Key sources only when scan enabled
`ifndef LSC_CONSTS_VH
`define LSC_CONSTS_VH
`define LSC_MODE_ADDR 8'h10
`define LSC_KSRC_ADDR 8'h42
`define LSC_MODE_RST 4'h0
`define LSC_KSRC_RST 16'h0000
`define LSC_BIT_DISP_EN 0
`define LSC_BIT_SCAN_EN 1
`define LSC_BIT_PORTE_EN 2
`define LSC_BIT_PORTF_EN 3
`define LSC_SEG_WORDS 15
`define LSC_CLK_HZ 40000000
`define LSC_DISP_CLK_HZ 250
`define LSC_SLOT_HZ (`LSC_DISP_CLK_HZ * 4)
`define LSC_SLOT_CYC (`LSC_CLK_HZ / `LSC_SLOT_HZ)
`endif

// [src/lsc_seg_mem.v]
/*
 Segment register store: fifteen nibbles in data memory space,
 two segment lines per nibble.
 Assumes a single-clock synchronous CPU write/read port.
*/
`default_nettype none
module lsc_seg_mem (
    // Clock and reset
    input wire clk,
    input wire rst_b,
    // CPU port
    input wire mem_wr,
    input wire [3:0] mem_addr,
    input wire [3:0] mem_wdata,
    output reg [3:0] mem_rdata_ff,
    // Flat view for the drivers
    output wire [59:0] seg_bits
);
    reg [3:0] mem_ff [0:14];
    integer i;
    genvar g;
    generate
        for (g = 0; g < 15; g = g + 1) begin : flat
            assign seg_bits[g*4+3:g*4] = mem_ff[g];
        end
    endgenerate
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (i = 0; i < 15; i = i + 1) begin
                mem_ff[i] <= 4'h0;
            end
            mem_rdata_ff <= 4'h0;
        end else begin
            if (mem_wr && mem_addr < 4'hF) begin
                mem_ff[mem_addr] <= mem_wdata; // R13
            end
            mem_rdata_ff <= (mem_addr < 4'hF) ? mem_ff[mem_addr] : 4'h0;
        end
    end
endmodule
`default_nettype wire

// [dv/lsc_key_matrix.sv]
/* Key matrix model: one closed key between column col_sel and return row 2.
   Assumes key source columns drive high; return rows are pulled low. */
`default_nettype none
module lsc_key_matrix (
    // Key source columns
    input wire logic [15:0] col,
    input wire logic [3:0] col_sel,
    // Return rows
    output logic [3:0] rows
);
    assign rows = col[col_sel] ? 4'h4 : 4'h0;
endmodule
`default_nettype wire

// [dv/lsc_driver_sva.sv]
/* Port checker for lsc_driver, bound after the module.
   Assumes the register map of the consts header. */
`include "lsc_consts.vh"
`default_nettype none
module lsc_driver_sva (
    // Clock, reset, CPU side
    input wire logic clk, rst_b, reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata, reg_rdata_ff,
    input wire logic [3:0] mem_addr, mem_rdata, key_return_ff,
    // Pins
    input wire logic common_line_a_ff, common_line_b_ff, common_a_mid_ff, common_b_mid_ff,
    input wire logic [29:0] seg_out_ff,
    input wire logic key_slot_ff
);
    logic [3:0] mode_ff;
    logic [15:0] ksr_ff;
    logic [1:0] quiet_ff;
    wire com_any = common_line_a_ff | common_line_b_ff | common_a_mid_ff | common_b_mid_ff;
    wire quiet = quiet_ff == 2'h3;
    // Register shadows and cycles since a write
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_ff <= 4'h0;
            ksr_ff <= 16'h0000;
            quiet_ff <= 2'h3;
        end else begin
            if (reg_wr && reg_addr == `LSC_MODE_ADDR) mode_ff <= reg_wdata[3:0];
            if (reg_wr && reg_addr == `LSC_KSRC_ADDR) ksr_ff <= reg_wdata;
            quiet_ff <= reg_wr ? 2'h0 : quiet_ff + {1'b0, !quiet};
        end
    end
    default clocking dc @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence s_off_wr;
        reg_wr && reg_addr == `LSC_MODE_ADDR && !reg_wdata[0] ##1 !reg_wr [*2];
    endsequence
    a_off_fast: assert property (s_off_wr |=> !com_any) else $error("commons live");
    a_off_low: assert property (quiet && !mode_ff[0] |-> !com_any) else $error("off");
    a_segs_off: assert property (quiet && mode_ff == 4'h0 |-> seg_out_ff == 30'h0)
        else $error("segments live");
    a_no_scan: assert property (quiet && !mode_ff[1] |-> !key_slot_ff && key_return_ff == 4'h0)
        else $error("scan live");
    a_ks_data: assert property (quiet && key_slot_ff |-> seg_out_ff[15:0] == ksr_ff)
        else $error("key data");
    a_mid_one: assert property (quiet && mode_ff[0] |-> common_a_mid_ff != common_b_mid_ff)
        else $error("bias");
    a_rd_mode: assert property (quiet && !reg_wr && reg_addr == `LSC_MODE_ADDR |=>
        reg_rdata_ff == {12'h000, mode_ff}) else $error("mode read");
    a_mem_top: assert property (mem_addr == 4'hF |=> mem_rdata == 4'h0) else $error("nib");
endmodule
bind lsc_driver lsc_driver_sva i_lsc_driver_sva (.*);
`default_nettype wire

// [dv/lsc_driver_tb_top.sv]
/* Bench for lsc_driver: registers, segment memory, waveforms, ports, keys.
   Assumes the consts header and the key matrix model. */
`include "lsc_consts.vh"
`default_nettype none
module lsc_driver_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst_b = 0, mem_wr = 0, reg_wr = 0, k0;
    logic [3:0] mem_addr = 0, mem_wdata = 0, col_sel = 0, nib [16];
    logic [7:0] reg_addr = 0;
    logic [15:0] reg_wdata = 0, key_source_data;
    wire [3:0] mem_rdata, keys, kr;
    wire [15:0] rdata;
    wire [29:0] seg;
    wire ca, cb, am, bm, ks;
    int seed = 84762, errors = 0, samples_checked = 0, n;
    always #12.5 clk = ~clk;
    lsc_driver i_lsc_driver (.clk(clk), .rst_b(rst_b), .mem_wr(mem_wr), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .reg_wr(reg_wr), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata_ff(rdata), .common_line_a_ff(ca),
        .common_line_b_ff(cb), .common_a_mid_ff(am), .common_b_mid_ff(bm), .seg_out_ff(seg),
        .key_return_port(keys), .key_return_ff(kr), .key_slot_ff(ks));
    lsc_key_matrix i_lsc_key_matrix (.col(seg[15:0]), .col_sel(col_sel), .rows(keys));
    task chk(input logic [63:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task final_report;
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task cyc(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask
    task wr(input logic r, input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= r;
        mem_wr <= !r;
        reg_addr <= a;
        mem_addr <= a[3:0];
        reg_wdata <= d;
        mem_wdata <= d[3:0];
        @(posedge clk);
        reg_wr <= 0;
        mem_wr <= 0;
    endtask
    task rd(input logic r, input logic [7:0] a, input logic [15:0] e);
        @(posedge clk);
        reg_addr <= a;
        mem_addr <= a[3:0];
        cyc(2);
        chk(r ? rdata : {12'h000, mem_rdata}, e);
    endtask
    // Lit dot drives the segment opposite to the selected common
    function logic exp_seg(int s);
        logic a, b;
        a = nib[s / 2][(s % 2) * 2];
        b = nib[s / 2][(s % 2) * 2 + 1];
        return (am ? b : a) ^ (am ? cb : ca);
    endfunction
    task pins;
        cyc(4);
        for (int s = 0; s < 26; s++) chk(seg[s], s < 16 && ks ? key_source_data[s] : exp_seg(s));
        chk(seg[29:26], nib[13]);
        if (ks) chk(kr, key_source_data[col_sel] ? 4'h4 : 4'h0);
    endtask
    task chg(output int c);
        logic [3:0] c0;
        c0 = {ca, cb, am, bm};
        c = 0;
        while ({ca, cb, am, bm} === c0 && c < 41000) begin
            cyc(1);
            c++;
        end
    endtask
    initial begin
        repeat (95000) @(posedge clk);
        errors++;
        final_report;
    end
    initial begin
        col_sel = $random(seed);
        key_source_data = $random(seed);
        for (int i = 0; i < 16; i++) nib[i] = $random(seed);
        repeat (16) @(posedge clk);
        rst_b <= 1;
        cyc(1);
        chk({ca, cb, am, bm, seg}, 0);
        rd(1, `LSC_MODE_ADDR, 0);
        rd(1, `LSC_KSRC_ADDR, 0);
        for (int i = 0; i < 16; i++) wr(0, i, nib[i]);
        nib[15] = 0;
        for (int i = 0; i < 16; i++) rd(0, i, nib[i]);
        wr(1, `LSC_KSRC_ADDR, key_source_data);
        wr(1, `LSC_MODE_ADDR, 16'h000B);
        rd(1, `LSC_KSRC_ADDR, key_source_data);
        rd(1, 8'h33, 0);
        rd(1, `LSC_MODE_ADDR, 16'h000B);
        pins;
        chg(n);
        k0 = ks;
        pins;
        chg(n);
        chk(n + 4, 40000);
        chk(ks, !k0);
        pins;
        wr(1, `LSC_MODE_ADDR, 16'h0006);
        cyc(4);
        chk({ca, cb, am, bm, seg[21:16], seg[29:26]}, 0);
        chk(seg[15:0], ks ? key_source_data : 16'h0000);
        chk(seg[25:22], nib[11]);
        wr(1, `LSC_MODE_ADDR, 0);
        cyc(4);
        chk({seg, ks, kr}, 0);
        final_report;
    end
endmodule
`default_nettype wire
